// ===== design/wdtrs_defines.svh
`ifndef WDTRS_DEFINES_SVH
`define WDTRS_DEFINES_SVH

// Key pattern that turns the watchdog off
`define WDTRS_KEY_OFF 4'ha
`define WDTRS_KEY_RECOMMENDED 4'h5
`define WDTRS_KEY_RESET 4'ha
`define WDTRS_SEL_RESET 3'h7
`define WDTRS_SEL_WIDTH 3
`define WDTRS_PERIOD_BASE_LOG2 8
`define WDTRS_CNT_WIDTH 16
`define WDTRS_PORT_RESET 8'hff
`define WDTRS_RST_DELAY_MS 50
`define WDTRS_CLK_MHZ 100
// 50 ms at 100 MHz, longest-form count kept as cycles
`define WDTRS_RST_DELAY_CYC (`WDTRS_RST_DELAY_MS * 1000 * `WDTRS_CLK_MHZ)
`define WDTRS_SRC_CRYSTAL 2'h0
`define WDTRS_SRC_SYSDIV4 2'h1
`define WDTRS_SRC_SLOW_RC 2'h2

`endif

// ===== design/wdtrs_pkg.sv
package wdtrs_pkg;
	typedef enum logic [1:0] {
		WDTRS_CLR_NONE,
		WDTRS_CLR_FIRST,
		WDTRS_CLR_SECOND
	} wdtrs_half_t;
	typedef enum logic [1:0] {
		WDTRS_RESET_HOLD,
		WDTRS_DELAY,
		WDTRS_RUN
	} wdtrs_state_t;
endpackage : wdtrs_pkg

// ===== design/wdtrs_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdtrs_defines.svh"

// Operation
// RULE1 - Build option forces watchdog on; otherwise the key field decides.
// RULE2 - Option off and key 1010B means watchdog off; key powers up 1010B.
// RULE3 - Any other key value enables; software should prefer 0101B.
// RULE4 - With watchdog disabled, watchdog instructions do nothing.
// RULE5 - Build option picks watchdog clock: crystal, system/4 or slow RC.
// RULE6 - Divided system clock source stops counting during sleep.
// RULE7 - Time-out is 2^(8+select) watchdog clock ticks.
// RULE8 - Select register bits 7..3 read zero; bits 2..0 read/write.
// RULE9 - Time-out while running resets device and sets time-out flag.
// RULE10 - Sleep time-out wakes, sets flag, clears only PC and stack.
// RULE11 - Count cleared by reset pin low, accepted clear, and halt.
// RULE12 - Build option picks single or paired clear instruction scheme.
// RULE13 - Single scheme: each clear instruction clears the count at once.
// RULE14 - Paired scheme: alternating halves clear; repeated half is ignored.
// RULE15 - Power-on reset sets program counter to zero.
// RULE16 - Power-on reset sets port data and direction registers all ones.
// RULE17 - After reset pin release, wait an extra 50 ms before running.
// RULE18 - Reset pin low while running restarts execution from address zero.
// RULE19 - Pin reset leaves some registers unchanged, unlike power-on reset.
// RULE20 - Low-voltage reset acts like the pin reset.
// RULE21 - Flags: POR 0,0; pin/low-voltage kept; time-out 1,kept; sleep 1,1.
// RULE22 - Halt sets power-down flag and clears time-out flag.
// RULE23 - Counter counts ticks, overflows at selected period, restarts at zero.
// RULE24 - Paired tracker remembers last half; cleared with count and reset.
module wdtrs_watchdog #(
	parameter bit CFG_WDT_ALWAYS_ON = 1'b0, // Build option: force watchdog on
	parameter logic [1:0] CFG_CLK_SRC = `WDTRS_SRC_SLOW_RC, // Build option source
	parameter bit CFG_PAIRED_CLEAR = 1'b0, // Build option: two-half clear
	parameter int RST_DELAY_CYC = `WDTRS_RST_DELAY_CYC // Reset delay cycles
) (
	input wire logic clk, // 100 MHz system clock
	input wire logic rst, // Power-on reset, synchronous high
	input wire logic external_reset_pin_n, // Reset pin, active low, async
	input wire logic low_voltage_reset, // Low-voltage detect, async
	input wire logic low_speed_crystal_clock, // Crystal clock level, async
	input wire logic slow_internal_rc_clock, // Internal RC clock level, async
	input wire logic sleeping, // Core is in sleep mode
	input wire logic halt_exec, // Halt instruction executed, pulse
	input wire logic single_clear_instruction, // Single clear, pulse
	input wire logic clear_first_half, // First half clear, pulse
	input wire logic clear_second_half, // Second half clear, pulse
	input wire logic sel_wr, // Write select register, pulse
	input wire logic [7:0] sel_wdata, // Select register write data
	input wire logic key_wr, // Write enable key field, pulse
	input wire logic [3:0] key_wdata, // Enable key write data
	output logic [7:0] timeout_select_register, // Select register read
	output logic [3:0] watchdog_enable_key, // Enable key field read
	output logic timeout_flag, // Time-out status flag
	output logic power_down_flag, // Power-down status flag
	output logic wdt_running, // Watchdog function is on
	output logic core_reset, // Full core reset level
	output logic pc_sp_clear, // Clear PC and stack pointer, pulse
	output logic wake_up, // Sleep wake request, pulse
	output logic por_ports_set, // Power-on port preset, level
	output logic [7:0] port_init_value // Value loaded into ports at POR
);
	logic [1:0] pin_sync_reg;
	logic [1:0] lowv_sync_reg;
	logic [2:0] xtal_sync_reg;
	logic [2:0] src_rc_sync_reg;
	logic [1:0] div4_reg;
	logic [`WDTRS_SEL_WIDTH-1:0] sel_reg;
	logic [3:0] key_reg;
	logic [`WDTRS_CNT_WIDTH-1:0] cnt_reg;
	logic to_reg;
	logic pdown_reg;
	logic [31:0] delay_reg;
	logic por_reg;
	logic pcsp_reg;
	logic wake_reg;
	wdtrs_pkg::wdtrs_half_t half_reg;
	wdtrs_pkg::wdtrs_state_t state_reg;
	logic pin_low;
	logic enabled;
	logic tick;
	logic sw_clear;
	logic cnt_clear;
	logic overflow;
	logic [`WDTRS_CNT_WIDTH-1:0] cnt_next;

	// Highest count value for a select code
	function automatic logic [`WDTRS_CNT_WIDTH-1:0] period_last(
		input logic [`WDTRS_SEL_WIDTH-1:0] sel
	);
		logic [`WDTRS_CNT_WIDTH:0] p;
		p = '0;
		p[`WDTRS_PERIOD_BASE_LOG2 + sel] = 1'b1;
		period_last = `WDTRS_CNT_WIDTH'(p - 1'b1);
	endfunction : period_last

	// Pins pass two flops before any use
	always_ff @(posedge clk) begin
		pin_sync_reg <= {pin_sync_reg[0], ~external_reset_pin_n};
		lowv_sync_reg <= {lowv_sync_reg[0], low_voltage_reset};
	end

	// Third stage feeds the edge detector only
	always_ff @(posedge clk) begin
		xtal_sync_reg <= {xtal_sync_reg[1:0], low_speed_crystal_clock};
		src_rc_sync_reg <= {src_rc_sync_reg[1:0], slow_internal_rc_clock};
	end

	// Pin and low-voltage resets share one path
	assign pin_low = pin_sync_reg[1] | lowv_sync_reg[1]; // RULE20

	// Instruction clock stops in sleep, so the divider freezes too
	always_ff @(posedge clk) begin
		if (rst) begin
			div4_reg <= 2'h0;
		end else if (!sleeping) begin // RULE6
			div4_reg <= div4_reg + 2'h1;
		end
	end

	always_comb begin
		unique case (CFG_CLK_SRC) // RULE5
			`WDTRS_SRC_CRYSTAL: tick = xtal_sync_reg[1] & ~xtal_sync_reg[2];
			`WDTRS_SRC_SYSDIV4: tick = (div4_reg == 2'h3) & ~sleeping; // RULE6
			default: tick = src_rc_sync_reg[1] & ~src_rc_sync_reg[2];
		endcase
	end

	assign enabled = CFG_WDT_ALWAYS_ON
		|| (key_reg != `WDTRS_KEY_OFF); // RULE1 RULE2 RULE3

	// Clear only when enabled and in the selected scheme
	always_comb begin
		sw_clear = 1'b0;
		if (enabled) begin // RULE4
			if (!CFG_PAIRED_CLEAR) begin // RULE12
				sw_clear = single_clear_instruction; // RULE13
			end else if (clear_first_half) begin
				sw_clear = (half_reg == wdtrs_pkg::WDTRS_CLR_SECOND); // RULE14
			end else if (clear_second_half) begin
				sw_clear = (half_reg == wdtrs_pkg::WDTRS_CLR_FIRST); // RULE14
			end
		end
	end

	// Halt clears the count only as a watchdog instruction
	assign cnt_clear = pin_low || sw_clear || (halt_exec && enabled); // RULE11
	assign overflow = enabled && tick && !cnt_clear
		// At or past the end, so shortening the period cannot skip it
		&& (cnt_reg >= period_last(sel_reg)); // RULE7 RULE23

	always_comb begin
		cnt_next = cnt_reg;
		if (cnt_clear || overflow || !enabled) begin
			cnt_next = '0; // RULE23
		end else if (tick) begin
			cnt_next = cnt_reg + `WDTRS_CNT_WIDTH'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst || core_reset) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Tracker remembers the last half that did not complete a clear
	always_ff @(posedge clk) begin
		if (rst || core_reset || cnt_clear) begin
			half_reg <= wdtrs_pkg::WDTRS_CLR_NONE; // RULE24
		end else if (enabled && clear_first_half) begin
			half_reg <= wdtrs_pkg::WDTRS_CLR_FIRST; // RULE24
		end else if (enabled && clear_second_half) begin
			half_reg <= wdtrs_pkg::WDTRS_CLR_SECOND;
		end
	end

	// Select register: POR, pin and running time-out load 111
	always_ff @(posedge clk) begin
		if (rst || core_reset) begin
			sel_reg <= `WDTRS_SEL_RESET;
		end else if (sel_wr) begin
			sel_reg <= sel_wdata[`WDTRS_SEL_WIDTH-1:0]; // RULE8
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			key_reg <= `WDTRS_KEY_RESET; // RULE2
		end else if (key_wr) begin
			key_reg <= key_wdata;
		end
	end

	// Reset sequencer: hold, then delay, then run
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= wdtrs_pkg::WDTRS_DELAY;
			delay_reg <= '0;
		end else if (pin_low) begin
			state_reg <= wdtrs_pkg::WDTRS_RESET_HOLD; // RULE18
			delay_reg <= '0;
		end else if (overflow && !sleeping) begin
			state_reg <= wdtrs_pkg::WDTRS_DELAY; // RULE9
			delay_reg <= '0;
		end else begin
			unique case (state_reg)
				wdtrs_pkg::WDTRS_RESET_HOLD: state_reg <= wdtrs_pkg::WDTRS_DELAY;
				wdtrs_pkg::WDTRS_DELAY: begin
					if (delay_reg >= 32'(RST_DELAY_CYC - 1)) begin // RULE17
						state_reg <= wdtrs_pkg::WDTRS_RUN;
					end
					delay_reg <= delay_reg + 32'h1;
				end
				wdtrs_pkg::WDTRS_RUN: state_reg <= wdtrs_pkg::WDTRS_RUN;
				// Unused code falls back into the reset delay
				default: state_reg <= wdtrs_pkg::WDTRS_DELAY;
			endcase
		end
	end

	// Time-out flag; a halt masks a same-cycle time-out, so the halt clear wins
	always_ff @(posedge clk) begin
		if (rst) begin
			to_reg <= 1'b0; // RULE21
		end else if (pin_low) begin
			to_reg <= to_reg; // RULE21 RULE19
		end else if (overflow) begin
			to_reg <= 1'b1; // RULE9 RULE10 RULE21
		end else if (halt_exec || sw_clear) begin
			to_reg <= 1'b0; // RULE22
		end
	end

	// Power-down flag; a time-out in sleep leaves it set
	always_ff @(posedge clk) begin
		if (rst) begin
			pdown_reg <= 1'b0; // RULE21
		end else if (pin_low || overflow) begin
			pdown_reg <= pdown_reg; // RULE21
		end else if (halt_exec) begin
			pdown_reg <= 1'b1; // RULE22
		end else if (sw_clear) begin
			pdown_reg <= 1'b0;
		end
	end

	// Sleep time-out: wake and clear only PC and stack
	always_ff @(posedge clk) begin
		if (rst) begin
			pcsp_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			pcsp_reg <= overflow && sleeping && !pin_low; // RULE10
			wake_reg <= overflow && sleeping && !pin_low;
		end
	end

	// Ports preset only by power-on, not by pin reset
	always_ff @(posedge clk) begin
		if (rst) begin
			por_reg <= 1'b1; // RULE15 RULE16
		end else begin
			por_reg <= 1'b0; // RULE19
		end
	end

	assign core_reset = (state_reg != wdtrs_pkg::WDTRS_RUN); // RULE15 RULE18
	assign timeout_select_register = {5'h00, sel_reg}; // RULE8
	assign watchdog_enable_key = key_reg;
	assign timeout_flag = to_reg;
	assign power_down_flag = pdown_reg;
	assign wdt_running = enabled;
	assign pc_sp_clear = pcsp_reg;
	assign wake_up = wake_reg;
	assign por_ports_set = por_reg;
	assign port_init_value = `WDTRS_PORT_RESET; // RULE16
endmodule : wdtrs_watchdog

`default_nettype wire

// ===== testbench/wdtrs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdtrs_core_model (
	input wire logic clk, // System clock
	output logic sleeping, // Core asleep
	output logic halt_exec, // Halt pulse
	output logic single_clear_instruction, // Clear pulse
	output logic clear_first_half, // First half pulse
	output logic clear_second_half, // Second half pulse
	output logic sel_wr, // Select write
	output logic [7:0] sel_wdata, // Select data
	output logic key_wr, // Key write
	output logic [3:0] key_wdata // Key data
);
	initial begin
		{sleeping, halt_exec, single_clear_instruction, sel_wr} = 4'h0;
		{key_wr, clear_first_half, clear_second_half} = 3'h0;
		sel_wdata = 8'h00;
		key_wdata = 4'h0;
	end
	// Kind 0 halt, 1 clear, 2 select, 3 key, 5/6 halves, else sleep level
	task automatic op(input int k, input logic [7:0] d);
		@(posedge clk);
		#1;
		sel_wdata = d;
		key_wdata = d[3:0];
		case (k)
			0: halt_exec = 1'b1;
			1: single_clear_instruction = 1'b1;
			2: sel_wr = 1'b1;
			3: key_wr = 1'b1;
			5: clear_first_half = 1'b1;
			6: clear_second_half = 1'b1;
			default: sleeping = d[0];
		endcase
		@(posedge clk);
		#1;
		{halt_exec, single_clear_instruction, sel_wr, key_wr} = 4'h0;
		{clear_first_half, clear_second_half} = 2'h0;
		// Stale data would hide a late capture
		sel_wdata = ~d;
		key_wdata = ~d[3:0];
	endtask : op
endmodule : wdtrs_core_model
`default_nettype wire

// ===== testbench/wdtrs_watchdog_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wdtrs_watchdog_asserts #(
	parameter bit CFG_WDT_ALWAYS_ON = 1'b0 // Force-on option
) (
	input wire logic clk, // Clock
	input wire logic rst, // Power-on reset
	input wire logic sleeping, // Core asleep
	input wire logic halt_exec, // Halt pulse
	input wire logic sel_wr, // Select write
	input wire logic [7:0] sel_wdata, // Select data
	input wire logic key_wr, // Key write
	input wire logic [3:0] key_wdata, // Key data
	input wire logic [7:0] timeout_select_register, // Select read
	input wire logic [3:0] watchdog_enable_key, // Key read
	input wire logic timeout_flag, // Time-out flag
	input wire logic power_down_flag, // Power-down flag
	input wire logic wdt_running, // Watchdog on
	input wire logic core_reset, // Core reset
	input wire logic pc_sp_clear, // PC clear pulse
	input wire logic wake_up, // Wake pulse
	input wire logic por_ports_set, // Port preset
	input wire logic [7:0] port_init_value // Port value
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_SEL_ZERO: assert property (timeout_select_register[7:3] == 5'h00)
		else $error("select upper bits not zero");
	AST_SEL_WR: assert property (sel_wr && !core_reset ##1 !core_reset
		|-> timeout_select_register[2:0] == $past(sel_wdata[2:0]))
		else $error("select write lost");
	AST_KEY_WR: assert property (key_wr |=> watchdog_enable_key == $past(key_wdata))
		else $error("key write lost");
	AST_RUNNING: assert property (wdt_running ==
		(CFG_WDT_ALWAYS_ON || watchdog_enable_key != 4'ha))
		else $error("enable decode wrong");
	AST_HALT: assert property (halt_exec && !core_reset |=> power_down_flag
		&& (!timeout_flag || $rose(timeout_flag)))
		else $error("halt flags wrong");
	AST_TO_RESET: assert property ($rose(timeout_flag) && !sleeping |-> core_reset)
		else $error("no reset on time-out");
	AST_WAKE: assert property ($rose(timeout_flag) && sleeping
		|-> !core_reset ##[0:2] (wake_up && pc_sp_clear && !core_reset))
		else $error("sleep time-out wake wrong");
	AST_WAKE_PULSE: assert property (wake_up |=> !wake_up)
		else $error("wake pulse too long");
	AST_POR: assert property ($fell(rst) |-> core_reset && por_ports_set
		&& port_init_value == 8'hff && !timeout_flag && !power_down_flag)
		else $error("power-on state wrong");
endmodule : wdtrs_watchdog_asserts
bind wdtrs_watchdog wdtrs_watchdog_asserts #(.CFG_WDT_ALWAYS_ON(CFG_WDT_ALWAYS_ON))
	u_chk (.clk, .rst, .sleeping, .halt_exec, .sel_wr, .sel_wdata, .key_wr,
	.key_wdata, .timeout_select_register, .watchdog_enable_key, .timeout_flag,
	.power_down_flag, .wdt_running, .core_reset, .pc_sp_clear, .wake_up,
	.por_ports_set, .port_init_value);
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdtrs_defines.svh"
module tb_top;
	logic clk, rst, external_reset_pin_n, low_voltage_reset, mon;
	logic low_speed_crystal_clock, slow_internal_rc_clock, sleeping, halt_exec;
	logic single_clear_instruction, clear_first_half, clear_second_half;
	logic sel_wr, key_wr, timeout_flag, power_down_flag, wdt_running;
	logic core_reset, pc_sp_clear, wake_up, por_ports_set;
	logic [7:0] sel_wdata, timeout_select_register, port_init_value;
	logic [3:0] key_wdata, watchdog_enable_key;
	logic timeout_flag2, running2, core_reset2, wake_up2, mon2;
	int fails, compares, n, i, hits, hits2;
	// Written value in the high byte, readback in the low byte
	logic [15:0] rows [4] = '{16'hff07, 16'h0000, 16'ha505, 16'hf800};
	wdtrs_core_model core (.clk, .sleeping, .halt_exec, .single_clear_instruction,
		.clear_first_half, .clear_second_half, .sel_wr, .sel_wdata, .key_wr,
		.key_wdata);
	wdtrs_watchdog #(.RST_DELAY_CYC(20)) uut (.clk, .rst, .external_reset_pin_n,
		.low_voltage_reset, .low_speed_crystal_clock, .slow_internal_rc_clock,
		.sleeping, .halt_exec, .single_clear_instruction, .clear_first_half,
		.clear_second_half, .sel_wr, .sel_wdata, .key_wr, .key_wdata,
		.timeout_select_register, .watchdog_enable_key, .timeout_flag,
		.power_down_flag, .wdt_running, .core_reset, .pc_sp_clear, .wake_up,
		.por_ports_set, .port_init_value);
	// Second build: forced on, paired clears, system clock/4 source
	wdtrs_watchdog #(.CFG_WDT_ALWAYS_ON(1'b1),
		.CFG_CLK_SRC(`WDTRS_SRC_SYSDIV4), .CFG_PAIRED_CLEAR(1'b1),
		.RST_DELAY_CYC(20)) uut_pair (.clk, .rst, .external_reset_pin_n,
		.low_voltage_reset, .low_speed_crystal_clock, .slow_internal_rc_clock,
		.sleeping, .halt_exec, .single_clear_instruction, .clear_first_half,
		.clear_second_half, .sel_wr, .sel_wdata, .key_wr, .key_wdata,
		.timeout_select_register(), .watchdog_enable_key(),
		.timeout_flag(timeout_flag2), .power_down_flag(),
		.wdt_running(running2), .core_reset(core_reset2), .pc_sp_clear(),
		.wake_up(wake_up2), .por_ports_set(), .port_init_value());
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Slow clock: one tick every 4 system cycles
	initial begin
		slow_internal_rc_clock = 1'b0;
		forever #20 slow_internal_rc_clock = ~slow_internal_rc_clock;
	end
	always @(posedge clk) if (mon && core_reset === 1'b1) hits++;
	always @(posedge clk) if (mon2 && (core_reset2 | wake_up2) === 1'b1) hits2++;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// Wait kinds: 0 reset released, 1 time-out flag, 2 wake pulse
	task automatic wait_for(input int w, input int lim, output int cnt);
		cnt = 0;
		while (!(w == 0 ? core_reset === 1'b0 : w == 1 ? timeout_flag === 1'b1
			: wake_up === 1'b1)) begin
			@(posedge clk);
			#1;
			cnt++;
			if (cnt > lim) begin
				fails++;
				$display("CHECK FAILED at %0t: wait timed out", $time);
				tally_and_finish();
			end
		end
	endtask : wait_for
	initial begin
		{fails, compares, hits, mon, hits2, mon2} = 0;
		{rst, external_reset_pin_n, low_voltage_reset} = 3'b110;
		low_speed_crystal_clock = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		check(8'(watchdog_enable_key), 8'h0a);
		check(timeout_select_register, 8'h07);
		check(8'({timeout_flag, power_down_flag, core_reset}), 8'h01);
		check(port_init_value, 8'hff);
		check(8'(running2), 8'h01);
		wait_for(0, 40, n);
		check(8'(n >= 17 && n <= 24), 8'h01);
		$display("Power-on reset test done");
		for (i = 0; i < 4; i++) begin
			core.op(2, rows[i][15:8]);
			check(timeout_select_register, rows[i][7:0]);
		end
		$display("Select register test done");
		repeat (1200) @(posedge clk);
		#1;
		check(8'({timeout_flag, core_reset, wdt_running}), 8'h00);
		core.op(3, 8'h05);
		check(8'({wdt_running, watchdog_enable_key}), 8'h15);
		wait_for(1, 1300, n);
		check(8'(n >= 1016 && n <= 1036), 8'h01);
		check(8'(core_reset), 8'h01);
		wait_for(0, 40, n);
		check({timeout_flag, timeout_select_register[6:0]}, 8'h87);
		$display("Time-out test done");
		core.op(2, 8'h00);
		mon = 1'b1;
		for (i = 0; i < 4; i++) begin
			repeat (600) @(posedge clk);
			core.op(1, 8'h00);
		end
		mon = 1'b0;
		check(8'(hits), 8'h00);
		$display("Clear test done");
		core.op(0, 8'h00);
		check(8'({timeout_flag, power_down_flag}), 8'h01);
		core.op(2, 8'h00);
		mon2 = 1'b1;
		core.op(4, 8'h01);
		wait_for(2, 1300, n);
		check(8'(n >= 1008 && n <= 1036), 8'h01);
		check(8'({timeout_flag, power_down_flag, core_reset}), 8'h06);
		repeat (100) @(posedge clk);
		#1;
		mon2 = 1'b0;
		check(8'(hits2), 8'h00);
		core.op(4, 8'h00);
		$display("Sleep wake test done");
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			#1;
			{external_reset_pin_n, low_voltage_reset} = i == 0 ? 2'b00 : 2'b11;
			repeat (4) @(posedge clk);
			#1;
			check(8'({timeout_flag, power_down_flag, core_reset}), 8'h07);
			{external_reset_pin_n, low_voltage_reset} = 2'b10;
			wait_for(0, 40, n);
			check(8'(n >= 17 && n <= 26), 8'h01);
		end
		$display("Pin and low-voltage reset test done");
		core.op(2, 8'h00);
		hits2 = 0;
		mon2 = 1'b1;
		for (i = 0; i < 8; i++) begin
			repeat (300) @(posedge clk);
			core.op(5 + i % 2, 8'h00);
		end
		check(8'(hits2), 8'h00);
		for (i = 0; i < 4; i++) begin
			repeat (300) @(posedge clk);
			core.op(6, 8'h00);
		end
		mon2 = 1'b0;
		check(8'(hits2 > 0), 8'h01);
		check(8'(timeout_flag2), 8'h01);
		$display("Paired clear test done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
